/* port_p_pkg.sv */
// register map, field layout and reset values of the port p pad configuration block
// assumes a single ahb-lite master and word-aligned single transfers
// Overview of operation
// - function-b bits 5..2 route pins to serial port
// - function-b bits 31..6, 1..0 read zero
// - open-drain bit: 0 push-pull, 1 open-drain
// - pull-up bit per pin, cleared at reset
// - input-enable bit per pin, cleared at reset
// - upper bits 31..7 read zero, ignore writes
// - after reset all pins plain, everything disabled
// - function-b at 0x0C, open-drain at 0x28
// - pull-up at 0x2C, input-enable at 0x38
`default_nettype none
package port_p_pkg;
    localparam int pin_count = 7;                      // pins of the port
    localparam logic [11:0] off_function_b = 12'h000C; // second function-select
    localparam logic [11:0] off_open_drain = 12'h0028; // output style
    localparam logic [11:0] off_pullup = 12'h002C;     // pull-up enables
    localparam logic [11:0] off_input_en = 12'h0038;   // input buffer enables
    localparam logic [11:0] off_output_en = 12'h0004;  // output enable
    localparam logic [11:0] off_data = 12'h0000;       // data out / pin in
    localparam logic [11:0] off_function_a = 12'h0008; // first function-select
    localparam logic [6:0] function_b_mask = 7'h3C;    // implemented bits 5..2
    localparam logic [6:0] pin_mask = 7'h7F;           // implemented bits 6..0
    localparam logic [6:0] reset_value = 7'h00;        // every field clears
    localparam int bit_data_out = 2;                   // serial data out pin
    localparam int bit_data_in = 3;                    // serial data in pin
    localparam int bit_clock = 4;                      // serial clock pin
    localparam int bit_frame = 5;                      // serial frame pin
    localparam logic [1:0] htrans_nonseq = 2'b10;      // ahb transfer type
    localparam logic [1:0] htrans_seq = 2'b11;         // ahb transfer type
endpackage
`default_nettype wire

/* port_p_sync.sv */
// two-flop synchroniser for the pad inputs
// assumes the pins are asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none
module port_p_sync #(
    parameter int width = 7 // bits synchronised
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, low
    input wire logic [width-1:0] async_in, // raw pin levels
    output logic [width-1:0] sync_out // synchronised levels
);
    // state: both stages in one struct
    typedef struct packed {
        logic [width-1:0] stage1_ff; // first stage, read only by stage two
        logic [width-1:0] stage2_ff; // second stage
    } sync_state_t;
    sync_state_t cur_ff;
    sync_state_t nxt_ff;
    // shift the raw level along
    always_comb begin
        nxt_ff.stage1_ff = async_in;
        nxt_ff.stage2_ff = cur_ff.stage1_ff;
    end
    // registers, constant on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    assign sync_out = cur_ff.stage2_ff;
endmodule
`default_nettype wire

/* port_p_pads.sv */
// pad configuration for the seven-pin port: registers, pad controls, serial routing
// assumes a single ahb-lite master; peripheral and pad wires on hclk
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module port_p_pads
    import port_p_pkg::*;
(
    input wire logic hclk, // system clock, 25 mhz
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    input wire logic [6:0] pin_in, // pad input levels
    output logic [6:0] pin_out, // pad output levels
    output logic [6:0] pin_oe, // pad output enables, high drives
    output logic [6:0] pin_pullup, // pad pull-up enables
    output logic [6:0] pin_input_buffer, // pad input buffer enables
    output logic [6:0] port_in, // gated pin input to the data path
    input wire logic serial_frame_select, // from serial port
    input wire logic serial_port_clock, // from serial port
    input wire logic serial_data_out, // from serial port
    output logic serial_data_in // to serial port
);
    // all state of the block
    typedef struct packed {
        logic [6:0] data_ff; // general port output data
        logic [6:0] output_en_ff; // general port output enables
        logic [6:0] function_a_ff; // first function-select
        logic [6:0] alt_function_select_b_ff; // second function-select
        logic [6:0] open_drain_select_ff; // driver style
        logic [6:0] pullup_enable_ff; // pull-ups
        logic [6:0] input_buffer_enable_ff; // input buffers
        logic wr_pend_ff; // write data phase follows
        logic [11:0] wr_addr_ff; // latched write offset
        logic [31:0] hrdata_ff; // read data
        logic [6:0] pin_out_ff; // pad outputs
        logic [6:0] pin_oe_ff; // pad enables
        logic [6:0] pin_pullup_ff; // pad pull-ups
        logic [6:0] pin_ibuf_ff; // pad input buffers
        logic [6:0] port_in_ff; // gated input
        logic serial_in_ff; // serial data in
    } pads_state_t;
    pads_state_t cur_ff;
    pads_state_t nxt_ff;
    logic [6:0] pin_sync; // synchronised pads
    logic [6:0] gated_in; // after the input buffer
    logic [6:0] serial_route; // pins handed to the serial port
    logic [6:0] drive_val; // wanted output level
    logic [6:0] drive_en; // wanted enable before open-drain
    logic take; // address phase accepted
    logic [31:0] rd_word; // read mux result
    port_p_sync #(.width(pin_count)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );
    // pad control, register writes and read mux
    always_comb begin
        nxt_ff = cur_ff;
        take = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq);
        // disabled buffer reads low
        gated_in = pin_sync & cur_ff.input_buffer_enable_ff;
        serial_route = cur_ff.alt_function_select_b_ff & function_b_mask;
        drive_val = cur_ff.data_ff;
        drive_en = cur_ff.output_en_ff;
        // function-a pins keep port data here; their bus owner lives elsewhere
        // serial pins: frame, clock, data out driven, data in only received
        if (serial_route[bit_frame]) begin
            drive_val[bit_frame] = serial_frame_select;
            drive_en[bit_frame] = 1'b1;
        end
        if (serial_route[bit_clock]) begin
            drive_val[bit_clock] = serial_port_clock;
            drive_en[bit_clock] = 1'b1;
        end
        if (serial_route[bit_data_out]) begin
            drive_val[bit_data_out] = serial_data_out;
            drive_en[bit_data_out] = 1'b1;
        end
        if (serial_route[bit_data_in]) begin
            drive_en[bit_data_in] = 1'b0;
        end
        // open-drain never drives high: enable only when low
        nxt_ff.pin_out_ff = drive_val;
        nxt_ff.pin_oe_ff = drive_en & ~(cur_ff.open_drain_select_ff & drive_val);
        nxt_ff.pin_pullup_ff = cur_ff.pullup_enable_ff;
        nxt_ff.pin_ibuf_ff = cur_ff.input_buffer_enable_ff;
        nxt_ff.port_in_ff = gated_in;
        nxt_ff.serial_in_ff = serial_route[bit_data_in] & gated_in[bit_data_in];
        // write data phase; only implemented bits stored
        if (cur_ff.wr_pend_ff) begin
            unique case (cur_ff.wr_addr_ff)
                off_data: nxt_ff.data_ff = hwdata[6:0] & pin_mask;
                off_output_en: nxt_ff.output_en_ff = hwdata[6:0] & pin_mask;
                off_function_a: nxt_ff.function_a_ff = hwdata[6:0] & pin_mask;
                off_function_b: nxt_ff.alt_function_select_b_ff = hwdata[6:0] & function_b_mask;
                off_open_drain: nxt_ff.open_drain_select_ff = hwdata[6:0] & pin_mask;
                off_pullup: nxt_ff.pullup_enable_ff = hwdata[6:0] & pin_mask;
                off_input_en: nxt_ff.input_buffer_enable_ff = hwdata[6:0] & pin_mask;
                default: ; // unmapped write ignored
            endcase
        end
        nxt_ff.wr_pend_ff = take && hwrite;
        nxt_ff.wr_addr_ff = haddr[11:0];
        // read mux, upper bits zero
        rd_word = 32'h0000_0000;
        unique case (haddr[11:0])
            off_data: rd_word[6:0] = cur_ff.port_in_ff;
            off_output_en: rd_word[6:0] = cur_ff.output_en_ff;
            off_function_a: rd_word[6:0] = cur_ff.function_a_ff;
            off_function_b: rd_word[6:0] = cur_ff.alt_function_select_b_ff;
            off_open_drain: rd_word[6:0] = cur_ff.open_drain_select_ff;
            off_pullup: rd_word[6:0] = cur_ff.pullup_enable_ff;
            off_input_en: rd_word[6:0] = cur_ff.input_buffer_enable_ff;
            default: ; // unmapped reads zero
        endcase
        nxt_ff.hrdata_ff = (take && !hwrite) ? rd_word : 32'h0000_0000;
    end
    // registers; all clear, pins plain and idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    assign hrdata = cur_ff.hrdata_ff;
    assign hreadyout = 1'b1; // zero wait states; constant is a flip-flop free level
    assign hresp = 1'b0;
    assign pin_out = cur_ff.pin_out_ff;
    assign pin_oe = cur_ff.pin_oe_ff;
    assign pin_pullup = cur_ff.pin_pullup_ff;
    assign pin_input_buffer = cur_ff.pin_ibuf_ff;
    assign port_in = cur_ff.port_in_ff;
    assign serial_data_in = cur_ff.serial_in_ff;

    // open-drain pin never enabled while high
    chk_open_drain_high: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(pin_oe & pin_out & $past(cur_ff.open_drain_select_ff))))
        else $error("open-drain pin driven high");
    // unimplemented function-b bits read zero
    chk_fb_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[11:0] == off_function_b) |=> (hrdata[31:6] == '0
        && hrdata[1:0] == 2'b00))
        else $error("function-b reserved bits not zero");
    // written pull-up value reaches the pad pull-up outputs two cycles later
    chk_pullup_store: assert property (@(posedge hclk) disable iff (!hresetn)
        (cur_ff.wr_pend_ff && cur_ff.wr_addr_ff == off_pullup)
        |=> ##1 (pin_pullup == $past(hwdata[6:0], 2)))
        else $error("pull-up write not applied");
    // disabled input buffer gives low
    chk_ibuf_low: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(port_in & ~$past(cur_ff.input_buffer_enable_ff))))
        else $error("disabled input not low");
    // input buffer output follows register
    chk_ibuf_pad: assert property (@(posedge hclk) disable iff (!hresetn)
        pin_input_buffer == $past(cur_ff.input_buffer_enable_ff))
        else $error("input buffer pad mismatch");
    // upper bits of width-7 registers read zero
    chk_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite) |=> hrdata[31:7] == '0)
        else $error("upper bits not zero");
    // serial clock pin driven when routed and push-pull
    chk_serial_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(cur_ff.alt_function_select_b_ff[bit_clock])
        && !$past(cur_ff.open_drain_select_ff[bit_clock]))
        |-> (pin_oe[bit_clock] && pin_out[bit_clock] == $past(serial_port_clock)))
        else $error("serial clock not routed");
    // open-drain register decoded at its offset
    chk_od_decode: assert property (@(posedge hclk) disable iff (!hresetn)
        (cur_ff.wr_pend_ff && cur_ff.wr_addr_ff == off_open_drain)
        |=> cur_ff.open_drain_select_ff == $past(hwdata[6:0]))
        else $error("open-drain write lost");
    // input-enable decoded at its offset
    chk_ie_decode: assert property (@(posedge hclk) disable iff (!hresetn)
        (cur_ff.wr_pend_ff && cur_ff.wr_addr_ff == off_input_en)
        |=> cur_ff.input_buffer_enable_ff == $past(hwdata[6:0]))
        else $error("input-enable write lost");
    // pins idle in the first cycle after reset
    chk_reset_idle: assert property (@(posedge hclk)
        $rose(hresetn) |-> (pin_oe == '0 && pin_pullup == '0 && pin_input_buffer == '0))
        else $error("pins not idle after reset");
    // function-b keeps only bits 5..2 of a write
    chk_fb_store_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        (cur_ff.wr_pend_ff && cur_ff.wr_addr_ff == off_function_b)
        |=> cur_ff.alt_function_select_b_ff == ($past(hwdata[6:0]) & function_b_mask))
        else $error("function-b write not masked");
    // a routed data-in pin is never driven by the pad
    chk_data_in_undriven: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(cur_ff.alt_function_select_b_ff[bit_data_in]) |-> !pin_oe[bit_data_in])
        else $error("serial data-in pin driven");
    // serial data in stays low unless its pin is routed
    chk_serial_in_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(cur_ff.alt_function_select_b_ff[bit_data_in]) |-> !serial_data_in)
        else $error("serial data in leaks from a plain pin");
    // the push-pull frame pin left at 0 in function-b keeps its general port enable
    chk_plain_port_oe: assert property (@(posedge hclk) disable iff (!hresetn)
        (!$past(cur_ff.alt_function_select_b_ff[bit_frame])
        && !$past(cur_ff.open_drain_select_ff[bit_frame]))
        |-> pin_oe[bit_frame] == $past(cur_ff.output_en_ff[bit_frame]))
        else $error("plain frame pin lost its port enable");
    // read of open-drain returns the stored bits
    chk_od_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[11:0] == off_open_drain)
        |=> hrdata[6:0] == $past(cur_ff.open_drain_select_ff))
        else $error("open-drain read mismatch");
    // read of pull-up returns the stored bits
    chk_pullup_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[11:0] == off_pullup)
        |=> hrdata[6:0] == $past(cur_ff.pullup_enable_ff))
        else $error("pull-up read mismatch");
    // read of input-enable returns the stored bits
    chk_ie_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[11:0] == off_input_en)
        |=> hrdata[6:0] == $past(cur_ff.input_buffer_enable_ff))
        else $error("input-enable read mismatch");
endmodule
`default_nettype wire

/* port_p_far_side.sv */
// far-side model: the seven pads with an outside driver and pull-ups
// assumes the bench decides when the outside world drives a pin
`timescale 1ns/1ps
`default_nettype none
module port_p_far_side (
    input wire logic hclk, // system clock
    input wire logic [6:0] pin_out, // pad drive level
    input wire logic [6:0] pin_oe, // pad drive enable, high drives
    input wire logic [6:0] pin_pullup, // pull-up enables
    input wire logic [6:0] ext_drive, // outside driver on
    input wire logic [6:0] ext_level, // outside driver level
    output logic [6:0] pin_in // resolved pad level
);
    logic [6:0] float_ff = 7'h00; // level of an undriven pin
    // an undriven pin flips every clock so it never looks steady
    always_ff @(posedge hclk) begin
        float_ff <= ~float_ff;
    end
    // the pad driver wins, then the outside world, then the pull-up
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_in[i] = ext_level[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_ff[i];
            end
        end
    end
endmodule
`default_nettype wire

/* port_p_pad_config_test.sv */
// testbench for the port p pad configuration block
// assumes one bus master, one clock, the far-side pad model
`timescale 1ns/1ps
`default_nettype none
module port_p_pad_config_test;
    import port_p_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp; // bus control
    logic [31:0] haddr, hwdata, hrdata; // bus address and data
    logic [1:0] htrans; // transfer type
    logic [6:0] pin_in, pin_out, pin_oe, pin_pullup, pin_input_buffer, port_in; // pads
    logic [6:0] ext_drive, ext_level; // outside world on the pins
    logic sfs, sck, sdo, sdi; // serial port side
    logic [31:0] rd; // last read word
    int num_errors = 0; // mismatches
    int n_tests = 0; // comparisons made
    port_p_pads dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .pin_input_buffer(pin_input_buffer), .port_in(port_in),
        .serial_frame_select(sfs), .serial_port_clock(sck),
        .serial_data_out(sdo), .serial_data_in(sdi));
    port_p_far_side far (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_drive(ext_drive), .ext_level(ext_level),
        .pin_in(pin_in));
    // 25 mhz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // verdict, the single end of the run
    task automatic report_and_stop();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // compare one value, report at once on mismatch
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // next edge with hready high, bounded so a hang ends the run
    task automatic wait_ready();
        for (int n = 0; n < 20; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        num_errors++;
        report_and_stop();
    endtask
    // one single word transfer; the slave is never slow but we wait anyway
    task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= htrans_nonseq;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0000_0000;
        wait_ready();
        rd = hrdata;
    endtask
    // registers reached through the bus: reset, masking, decode, unmapped
    task automatic regs_scenario(input logic [31:0] wdata, input logic hit);
        logic [11:0] offs [5] = '{off_function_b, off_open_drain, off_pullup,
            off_input_en, 12'h0010};
        logic [31:0] masks [5] = '{32'h0000_003C, 32'h0000_007F, 32'h0000_007F,
            32'h0000_007F, 32'h0000_0000};
        for (int i = 0; i < 5; i++) begin
            if (hit) xfer(offs[i], 1'b1, wdata);
            xfer(offs[i], 1'b0, 32'h0000_0000);
            check(rd, wdata & masks[i]);
            check({hreadyout, hresp}, 2'b10);
        end
    endtask
    // reset in mid-run: pins plain again and function-b, open-drain, pull-up and input-enable read zero
    task automatic reset_scenario();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check({pin_oe, pin_pullup, pin_input_buffer, port_in}, 28'h000_0000);
        check({pin_out, sdi}, 8'h00);
        regs_scenario(32'h0000_0000, 1'b0);
    endtask
    // write, then let the pad outputs settle a fixed few edges
    task automatic cfg(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        repeat (5) @(posedge hclk);
    endtask
    // pull-ups and input buffers; a closed buffer reads low while pins float
    task automatic pad_scenario();
        cfg(off_pullup, 32'h0000_0055);
        check(pin_pullup, 7'h55);
        ext_drive <= 7'h7F;
        ext_level <= 7'h7F;
        cfg(off_input_en, 32'h0000_000F);
        check(pin_input_buffer, 7'h0F);
        check(port_in, 7'h0F);
        ext_drive <= 7'h00;
        cfg(off_pullup, 32'h0000_0000);
        check(port_in[6:4], 3'h0);
    endtask
    // serial routing on pins 5..2, checked with both levels of each signal
    task automatic serial_scenario(input logic v);
        cfg(off_output_en, 32'h0000_007F);
        cfg(off_function_b, 32'h0000_003C); // function-a stays 0
        sfs <= v;
        sck <= ~v;
        sdo <= v;
        ext_drive <= 7'h08;
        ext_level <= {3'b000, v, 3'b000};
        repeat (5) @(posedge hclk);
        check({pin_out[5], pin_out[4], pin_out[2]}, {v, ~v, v});
        check(pin_oe[3], 1'b0);
        check(sdi, v);
        cfg(off_function_b, 32'h0000_0000);
        check(pin_oe, 7'h7F);
    endtask
    // open-drain never drives high; push-pull drives high
    task automatic drain_scenario();
        cfg(off_data, 32'h0000_007F);
        cfg(off_open_drain, 32'h0000_007F);
        check(pin_oe, 7'h00);
        cfg(off_data, 32'h0000_0000);
        check({pin_oe, pin_out}, {7'h7F, 7'h00});
        cfg(off_open_drain, 32'h0000_0000);
        cfg(off_data, 32'h0000_007F);
        check({pin_oe, pin_out}, {7'h7F, 7'h7F});
    endtask
    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        ext_drive = 7'h00;
        ext_level = 7'h00;
        {sfs, sck, sdo} = 3'b000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({pin_oe, pin_pullup, pin_input_buffer, port_in}, 28'h000_0000);
        regs_scenario(32'h0000_0000, 1'b0);
        regs_scenario(32'hFFFF_FFFF, 1'b1);
        regs_scenario(32'h0000_0000, 1'b1);
        pad_scenario();
        serial_scenario(1'b1);
        serial_scenario(1'b0);
        drain_scenario();
        reset_scenario();
        report_and_stop();
    end
endmodule
`default_nettype wire
